// ---- hw/plqr_defines.vh ----
/*
  constants for the law translation and quadrant bit replacement block:
  register offsets, field positions, code masks and companding constants.
  assumes it is included by bare name from the design file.
*/
`ifndef PLQR_DEFINES_VH
`define PLQR_DEFINES_VH

// register offsets on the 14-bit microprocessor address
`define PLQR_QUAD_BASE 14'h0120
`define PLQR_QUAD_LAST 14'h012F
`define PLQR_CMH_BASE 14'h2000
`define PLQR_CMH_IDX_W 10

// high connection memory word fields
`define PLQR_CMH_W 5
`define PLQR_CMH_VD 4
`define PLQR_CMH_IL_HI 3
`define PLQR_CMH_IL_LO 2
`define PLQR_CMH_OL_HI 1
`define PLQR_CMH_OL_LO 0
`define PLQR_CMH_RST 5'h00

// quadrant control register: four 3-bit fields, bits 15-12 read zero
`define PLQR_QREG_W 12
`define PLQR_QFLD_W 3
`define PLQR_QREG_RST 12'h000
`define PLQR_QSHIFT_MIN 3

// quadrant action field bits
`define PLQR_QACT_EN 2
`define PLQR_QACT_MSB 1
`define PLQR_QACT_VAL 0

// law codes
`define PLQR_LAW_0 2'h0
`define PLQR_LAW_1 2'h1
`define PLQR_LAW_2 2'h2
`define PLQR_LAW_3 2'h3

// inversion masks
`define PLQR_MASK_NONE 8'h00
`define PLQR_MASK_EVEN 8'h55
`define PLQR_MASK_ODD 8'hAA
`define PLQR_MASK_ALL 8'hFF
`define PLQR_MASK_SIGN 8'h80

// companding constants on a 16-bit magnitude scale
`define PLQR_A_SEG0_RND 16'h0008
`define PLQR_A_SEG_BASE 16'h0108
`define PLQR_MU_BIAS 16'h0084
`define PLQR_SEG_LOW_BIT 7
`define PLQR_A_TOP_BIT 15
`define PLQR_MU_TOP_BIT 14
`define PLQR_MANT_SHIFT 3

`endif

// ---- hw/plqr_codec.v ----
/*
  per-channel law translation on the switched byte and per-stream quadrant
  bit replacement on input bytes, with quadrant and high connection memory
  registers behind the microprocessor port.
  assumes stream rate per input byte is supplied by the stream control
  logic, and that the switch core presents each switched byte with its
  output channel index.
*/
// Contract
// - translate in connection and message mode
// - bit 4 selects voice or data
// - input law bits 3-2, output 1-0
// - voice codes: A, mu, A-noABI, mu-noMI
// - A without ALTERNATE_BIT_FLIP keeps even bits
// - mu without MI keeps magnitude bits
// - data codes: none, even, odd, all
// - convert when laws differ, else pass
// - never convert voice to data
// - quadrants are quarter frame per rate
// - four 3-bit quadrant fields per stream
// - 0xx pass, 1xx force LSB/MSB
// - replacement on every configured input channel
// - high word bits 15-5 ignored, read zero
`timescale 1ns/1ns
`default_nettype none
`include "plqr_defines.vh"

module plqr_codec #(
  parameter NUM_STREAMS = 16,
  parameter CMH_DEPTH = 1024
) (
  input wire clk, // core clock, 250 MHz
  input wire sys_rst, // synchronous reset, high
  input wire reg_cs, // port select, high
  input wire reg_wr, // write strobe, one cycle
  input wire reg_rd, // read strobe, one cycle
  input wire [13:0] reg_addr, // register address
  input wire [15:0] reg_wdata, // write data
  output reg [15:0] reg_rdata, // read data, registered
  output reg reg_ack, // access done, one cycle
  input wire in_valid, // input byte present
  input wire [3:0] in_stream, // input stream number
  input wire [7:0] in_chan, // input channel number
  input wire [1:0] in_rate, // stream rate 0..3 = 2/4/8/16 Mbps
  input wire [7:0] in_byte, // received byte
  output reg st_valid, // byte to data memory
  output reg [3:0] st_stream, // its stream
  output reg [7:0] st_chan, // its channel
  output reg [7:0] st_byte, // byte after replacement
  input wire sw_valid, // switched byte present
  output wire sw_ready, // buffer has room
  input wire [`PLQR_CMH_IDX_W-1:0] sw_chan, // output channel index
  input wire [7:0] sw_byte, // switched byte
  output wire out_valid, // translated byte present
  input wire out_ready, // receiver takes it
  output wire [`PLQR_CMH_IDX_W-1:0] out_chan, // output channel index
  output wire [7:0] out_byte // translated byte
);
  // high connection memory storage, 5 bits per output channel
  reg [`PLQR_CMH_W-1:0] cmh_mem [0:CMH_DEPTH-1];
  // quadrant control registers, one per stream
  wire [`PLQR_QREG_W-1:0] quad_reg [0:NUM_STREAMS-1];
  // address decode strobes
  wire acc_wr, acc_rd, hit_quad, hit_cmh;
  wire [3:0] quad_idx;
  wire [`PLQR_CMH_IDX_W-1:0] cmh_idx;
  integer k;
  assign acc_wr = reg_cs & reg_wr;
  assign acc_rd = reg_cs & reg_rd;
  assign hit_quad = (reg_addr >= `PLQR_QUAD_BASE) && (reg_addr <= `PLQR_QUAD_LAST);
  assign hit_cmh = (reg_addr >= `PLQR_CMH_BASE) &&
                   (reg_addr < `PLQR_CMH_BASE + CMH_DEPTH);
  assign quad_idx = reg_addr[3:0];
  assign cmh_idx = reg_addr[`PLQR_CMH_IDX_W-1:0];
  // one quadrant register per stream
  genvar g;
  generate
    for (g = 0; g < NUM_STREAMS; g = g + 1) begin : gen_quad
      reg [`PLQR_QREG_W-1:0] q;
      always @(posedge clk) begin
        if (sys_rst) begin
          q <= `PLQR_QREG_RST;
        end else if (acc_wr && hit_quad && (quad_idx == g)) begin
          q <= reg_wdata[`PLQR_QREG_W-1:0];
        end
      end
      assign quad_reg[g] = q;
    end
  endgenerate

  // high connection memory writes
  always @(posedge clk) begin
    if (sys_rst) begin
      for (k = 0; k < CMH_DEPTH; k = k + 1) begin
        cmh_mem[k] <= `PLQR_CMH_RST;
      end
    end else if (acc_wr && hit_cmh) begin
      cmh_mem[cmh_idx] <= reg_wdata[`PLQR_CMH_W-1:0];
    end
  end

  // read mux and access acknowledge
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= acc_wr | acc_rd;
      if (acc_rd) begin
        if (hit_quad) begin
          reg_rdata <= {{(16-`PLQR_QREG_W){1'b0}}, quad_reg[quad_idx]};
        end else if (hit_cmh) begin
          reg_rdata <= {{(16-`PLQR_CMH_W){1'b0}}, cmh_mem[cmh_idx]};
        end else begin
          reg_rdata <= 16'h0000;
        end
      end
    end
  end

  // input side: quadrant pick and bit replacement
  wire [`PLQR_QREG_W-1:0] in_qreg;
  wire [7:0] chan_shift;
  wire [1:0] in_quad;
  wire [`PLQR_QFLD_W-1:0] qact;
  reg [7:0] repl_byte;
  assign in_qreg = quad_reg[in_stream];
  // quadrant size doubles with each rate step
  assign chan_shift = in_chan >> (`PLQR_QSHIFT_MIN + in_rate);
  assign in_quad = chan_shift[1:0];
  assign qact = in_qreg[in_quad*`PLQR_QFLD_W +: `PLQR_QFLD_W];
  // replacement action on the incoming byte
  always @* begin
    repl_byte = in_byte;
    // force LSB or MSB per field
    if (qact[`PLQR_QACT_EN]) begin
      if (qact[`PLQR_QACT_MSB]) begin
        repl_byte[7] = qact[`PLQR_QACT_VAL];
      end else begin
        repl_byte[0] = qact[`PLQR_QACT_VAL];
      end
    end
  end

  // replaced byte is what gets stored
  always @(posedge clk) begin
    if (sys_rst) begin
      st_valid <= 1'b0;
      st_stream <= 4'h0;
      st_chan <= 8'h00;
      st_byte <= 8'h00;
    end else begin
      // applies to every channel of the stream
      st_valid <= in_valid;
      st_stream <= in_stream;
      st_chan <= in_chan;
      st_byte <= repl_byte;
    end
  end

  // data-code inversion mask for a law field
  function [7:0] data_mask;
    input [1:0] law;
    begin
      case (law)
        `PLQR_LAW_0: data_mask = `PLQR_MASK_NONE;
        `PLQR_LAW_1: data_mask = `PLQR_MASK_EVEN;
        `PLQR_LAW_2: data_mask = `PLQR_MASK_ODD;
        default: data_mask = `PLQR_MASK_ALL;
      endcase
    end
  endfunction

  // line-to-raw mask for a voice law; odd codes are mu-law
  function [7:0] voice_mask;
    input [1:0] law;
    begin
      case (law)
        `PLQR_LAW_0: voice_mask = `PLQR_MASK_EVEN;
        `PLQR_LAW_1: voice_mask = `PLQR_MASK_ALL;
        `PLQR_LAW_2: voice_mask = `PLQR_MASK_NONE;
        default: voice_mask = `PLQR_MASK_SIGN;
      endcase
    end
  endfunction

  // A-law segment and mantissa to magnitude
  function [15:0] a_mag;
    input [6:0] c;
    reg [15:0] t;
    begin
      t = {8'h00, c[3:0], 4'h0};
      if (c[6:4] == 3'h0) begin
        a_mag = t + `PLQR_A_SEG0_RND;
      end else begin
        a_mag = (t + `PLQR_A_SEG_BASE) << (c[6:4] - 3'h1);
      end
    end
  endfunction

  // mu-law segment and mantissa to magnitude
  function [15:0] mu_mag;
    input [6:0] c;
    reg [15:0] t;
    begin
      t = {9'h000, c[3:0], 3'h0};
      mu_mag = ((t + `PLQR_MU_BIAS) << c[6:4]) - `PLQR_MU_BIAS;
    end
  endfunction

  // magnitude to A-law segment and mantissa
  function [6:0] a_enc;
    input [15:0] m;
    reg [15:0] s;
    reg [2:0] e;
    integer i;
    begin
      e = 3'h0;
      for (i = 1; i < `PLQR_A_TOP_BIT - `PLQR_SEG_LOW_BIT; i = i + 1) begin
        if (m[i + `PLQR_SEG_LOW_BIT]) begin
          e = i[2:0];
        end
      end
      if (e == 3'h0) begin
        s = m >> (`PLQR_MANT_SHIFT + 1);
      end else begin
        s = m >> (e + `PLQR_MANT_SHIFT);
      end
      a_enc = {e, s[3:0]};
    end
  endfunction

  // magnitude to mu-law segment and mantissa
  function [6:0] mu_enc;
    input [15:0] m;
    reg [15:0] v;
    reg [15:0] s;
    reg [2:0] e;
    integer i;
    begin
      v = m + `PLQR_MU_BIAS;
      e = 3'h0;
      for (i = 0; i <= `PLQR_MU_TOP_BIT - `PLQR_SEG_LOW_BIT; i = i + 1) begin
        if (v[i + `PLQR_SEG_LOW_BIT]) begin
          e = i[2:0];
        end
      end
      s = v >> (e + `PLQR_MANT_SHIFT);
      mu_enc = {e, s[3:0]};
    end
  endfunction

  // full translation of one switched byte
  function [7:0] translate;
    input [7:0] b;
    input [`PLQR_CMH_W-1:0] w;
    reg [1:0] il;
    reg [1:0] ol;
    reg [7:0] raw;
    reg neg;
    reg [6:0] code;
    begin
      // law fields of the high word
      il = w[`PLQR_CMH_IL_HI:`PLQR_CMH_IL_LO];
      ol = w[`PLQR_CMH_OL_HI:`PLQR_CMH_OL_LO];
      raw = b ^ voice_mask(il);
      neg = il[0] ? raw[7] : ~raw[7];
      if (il[0] == ol[0]) begin
        code = raw[6:0];
      end else if (il[0]) begin
        code = a_enc(mu_mag(raw[6:0]));
      end else begin
        code = mu_enc(a_mag(raw[6:0]));
      end
      // bit 4 chooses data code set
      if (w[`PLQR_CMH_VD]) begin
        translate = b ^ data_mask(il) ^ data_mask(ol);
      end else begin
        translate = {(ol[0] ? neg : ~neg), code} ^ voice_mask(ol);
      end
    end
  endfunction

  // two-entry output buffer
  reg [7:0] buf_byte [0:1];
  reg [`PLQR_CMH_IDX_W-1:0] buf_chan [0:1];
  reg wr_ptr, rd_ptr;
  reg [1:0] buf_cnt;
  wire push, pop;
  assign sw_ready = (buf_cnt != 2'h2);
  assign push = sw_valid & sw_ready;
  assign out_valid = (buf_cnt != 2'h0);
  assign pop = out_valid & out_ready;
  assign out_byte = buf_byte[rd_ptr];
  assign out_chan = buf_chan[rd_ptr];
  // buffer fill, drain and occupancy
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      buf_cnt <= 2'h0;
      buf_byte[0] <= 8'h00;
      buf_byte[1] <= 8'h00;
      buf_chan[0] <= {`PLQR_CMH_IDX_W{1'b0}};
      buf_chan[1] <= {`PLQR_CMH_IDX_W{1'b0}};
    end else begin
      if (push) begin
        buf_byte[wr_ptr] <= translate(sw_byte, cmh_mem[sw_chan]);
        buf_chan[wr_ptr] <= sw_chan;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        buf_cnt <= buf_cnt + 2'h1;
      end else if (pop && !push) begin
        buf_cnt <= buf_cnt - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/plqr_codec_monitor.sv ----
/*
  port checker for plqr_codec: register answers, input path, output buffer.
  assumes it is bound to every plqr_codec instance, one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module plqr_monitor (
  input wire logic clk, // core clock
  input wire logic sys_rst, // sync reset, high
  input wire logic reg_cs, // port select
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [13:0] reg_addr, // address
  input wire logic [15:0] reg_rdata, // read data
  input wire logic reg_ack, // access done
  input wire logic in_valid, // input byte present
  input wire logic [3:0] in_stream, // input stream
  input wire logic [7:0] in_chan, // input channel
  input wire logic [7:0] in_byte, // input byte
  input wire logic st_valid, // stored byte present
  input wire logic [3:0] st_stream, // stored stream
  input wire logic [7:0] st_chan, // stored channel
  input wire logic [7:0] st_byte, // stored byte
  input wire logic sw_valid, // switched byte offered
  input wire logic sw_ready, // buffer has room
  input wire logic out_valid, // buffer not empty
  input wire logic out_ready, // receiver takes
  input wire logic [9:0] out_chan, // buffered channel
  input wire logic [7:0] out_byte // buffered byte
);
  logic rq; // any register access taken
  assign rq = reg_cs && (reg_wr || reg_rd);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_follows: assert property (rq |=> reg_ack)
    else $error("register access without ack");
  a_ack_cause: assert property (reg_ack |-> $past(rq))
    else $error("ack without access");
  a_quad_top_zero: assert property (reg_ack && $past(reg_rd && reg_addr[13:4] == 10'h012)
    |-> reg_rdata[15:12] == 4'h0) else $error("quadrant read top bits set");
  a_high_top_zero: assert property (reg_ack && $past(reg_rd && reg_addr[13:10] == 4'h8)
    |-> reg_rdata[15:5] == 11'h000) else $error("high word read top bits set");
  a_st_follows: assert property (st_valid |-> $past(in_valid) &&
    st_stream == $past(in_stream) && st_chan == $past(in_chan)) else $error("stored tag wrong");
  a_mid_bits_kept: assert property (st_valid |-> st_byte[6:1] == $past(in_byte[6:1]))
    else $error("replacement touched middle bits");
  a_out_hold: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_byte) && $stable(out_chan)) else $error("offered byte moved");
  a_take_shows: assert property (sw_valid && sw_ready && !out_valid |=> out_valid)
    else $error("taken byte not offered");
  a_ready_empty: assert property (!out_valid |-> sw_ready)
    else $error("empty buffer refuses");
  cover property (rq && reg_wr);
  cover property (out_valid && !out_ready);
  cover property (!sw_ready);
endmodule
bind plqr_codec plqr_monitor mon_u (
  .clk(clk), .sys_rst(sys_rst), .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .in_valid(in_valid),
  .in_stream(in_stream), .in_chan(in_chan), .in_byte(in_byte), .st_valid(st_valid),
  .st_stream(st_stream), .st_chan(st_chan), .st_byte(st_byte), .sw_valid(sw_valid),
  .sw_ready(sw_ready), .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan),
  .out_byte(out_byte)
);
`default_nettype wire

// ---- tb/plqr_sink.sv ----
/*
  far-side receiver of translated bytes, stalling at random or on demand.
  assumes the bench reads its queue of received channel/byte pairs.
*/
`timescale 1ns/1ns
`default_nettype none
module plqr_sink (
  input wire logic clk, // core clock
  input wire logic stall, // hold off completely
  input wire logic out_valid, // byte offered
  input wire logic [9:0] out_chan, // its channel
  input wire logic [7:0] out_byte, // the byte
  output logic out_ready // takes the byte
);
  logic [17:0] got[$]; // received pairs in order
  initial out_ready = 1'b0;
  // take on handshake, then pick next readiness just after the edge
  always @(posedge clk) begin
    if (out_valid && out_ready) got.push_back({out_chan, out_byte});
    out_ready <= #1 !stall && ($urandom % 4 != 0);
  end
endmodule
`default_nettype wire

// ---- tb/tb_plqr_codec.sv ----
/*
  self-checking bench for plqr_codec: registers, quadrant replacement, translation.
  assumes the checker is bound and plqr_sink stands on the output side.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_plqr_codec;
  logic clk, sys_rst, reg_cs, reg_wr, reg_rd, in_valid, sw_valid, stall;
  logic [13:0] reg_addr;
  logic [15:0] reg_wdata, rd;
  logic [3:0] in_stream, s;
  logic [7:0] in_chan, in_byte, sw_byte, ch, b;
  logic [1:0] in_rate, r, q;
  logic [9:0] sw_chan, c;
  logic [11:0] qv;
  logic [2:0] f;
  wire logic [15:0] reg_rdata;
  wire logic [9:0] out_chan;
  wire logic [7:0] st_byte, st_chan, out_byte;
  wire logic [3:0] st_stream;
  wire logic reg_ack, st_valid, sw_ready, out_valid, out_ready;
  integer failures = 0, n_tests = 0, cyc = 0, i, k;
  logic [17:0] exp_q[$]; // expected channel/byte pairs
  plqr_codec dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .in_valid(in_valid), .in_stream(in_stream), .in_chan(in_chan), .in_rate(in_rate),
    .in_byte(in_byte), .st_valid(st_valid), .st_stream(st_stream), .st_chan(st_chan),
    .st_byte(st_byte), .sw_valid(sw_valid), .sw_ready(sw_ready), .sw_chan(sw_chan),
    .sw_byte(sw_byte), .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan),
    .out_byte(out_byte)
  );
  plqr_sink snk_u (
    .clk(clk), .stall(stall), .out_valid(out_valid), .out_chan(out_chan),
    .out_byte(out_byte), .out_ready(out_ready)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) if (++cyc == 20000) begin
    failures++;
    finish_test();
  end
  task chk(input string nm, input logic [17:0] ex, input logic [17:0] got);
    n_tests++;
    if (got !== ex) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task reg_acc(input logic wr, input logic [13:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    reg_cs = 1; reg_wr = wr; reg_rd = !wr; reg_addr = a; reg_wdata = d;
    @(posedge clk) #1;
    reg_cs = 0; reg_wr = 0; reg_rd = 0; rd = reg_rdata;
    chk("reg_ack", 1, reg_ack);
  endtask
  task push(input logic [9:0] pc, input logic [7:0] pb, input logic [7:0] pe);
    @(posedge clk) #1;
    sw_valid = 1; sw_chan = pc; sw_byte = pb;
    for (k = 0; sw_ready !== 1'b1 && k < 50; k++) @(posedge clk) #1;
    @(posedge clk) #1;
    sw_valid = 0;
    exp_q.push_back({pc, pe});
  endtask
  // one voice case across law families with a fixed expected byte
  task xl(input logic [4:0] w, input logic [7:0] bi, input logic [7:0] bo);
    c = 10'($urandom);
    reg_acc(1, 14'h2000 + c, {11'h7FF, w});
    push(c, bi, bo);
  endtask
  // expected byte after quadrant replacement
  function logic [7:0] rep(input logic [2:0] fc, input logic [7:0] v);
    rep = v;
    if (fc[2] && fc[1]) rep[7] = fc[0];
    else if (fc[2]) rep[0] = fc[0];
  endfunction
  // inversion of a law code relative to the raw value
  function logic [7:0] msk(input logic vd, input logic [1:0] l);
    if (vd) msk = {4{l}};
    else msk = (l == 0) ? 8'h55 : (l == 1) ? 8'hFF : (l == 3) ? 8'h80 : 8'h00;
  endfunction
  task finish_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {reg_cs, reg_wr, reg_rd, in_valid, sw_valid, stall, in_stream, in_rate} = 0;
    {reg_addr, reg_wdata, in_chan, in_byte, sw_byte, sw_chan} = 0;
    sys_rst = 1;
    void'($urandom(32'hD381));
    repeat (8) @(posedge clk);
    #1 sys_rst = 0;
    for (i = 0; i < 16; i++) begin
      reg_acc(0, 14'h0120 + i, 16'h0000);
      chk("quad reset", 0, rd);
    end
    reg_acc(0, 14'h0130, 16'h0000);
    chk("unmapped", 0, rd);
    $display("test reset done");
    for (i = 0; i < 48; i++) begin
      s = 4'($urandom); r = 2'($urandom); ch = 8'($urandom % (32 << r));
      q = 2'(ch >> (3 + r)); f = (i < 8) ? i[2:0] : 3'($urandom);
      qv = 12'($urandom); qv[3 * q +: 3] = f;
      // no bit error reception runs beside replacement
      reg_acc(1, 14'h0120 + s, {4'hF, qv});
      reg_acc(0, 14'h0120 + s, 16'h0000);
      chk("quad reg", {4'h0, qv}, rd);
      b = 8'($urandom);
      @(posedge clk) #1;
      in_valid = 1; in_stream = s; in_rate = r; in_chan = ch; in_byte = b;
      @(posedge clk) #1;
      in_valid = 0;
      chk("st_byte", rep(f, b), st_byte);
      chk("st tag", {1'b1, s, ch}, {st_valid, st_stream, st_chan});
    end
    $display("test quadrant done");
    stall = 1;
    push(10'h001, 8'h3C, 8'h3C);
    push(10'h002, 8'hC3, 8'hC3);
    chk("sw_ready full", 0, sw_ready);
    stall = 0;
    for (i = 0; i < 32; i++) begin
      if (!i[4] && i[2] != i[0]) continue;
      c = 10'($urandom); b = 8'($urandom);
      reg_acc(1, 14'h2000 + c, {11'($urandom), i[4:0]});
      reg_acc(0, 14'h2000 + c, 16'h0000);
      chk("high word", {11'h000, i[4:0]}, rd);
      push(c, b, b ^ msk(i[4], i[3:2]) ^ msk(i[4], i[1:0]));
    end
    // full scale and smallest codes across the two voice families
    xl(5'h01, 8'hAA, 8'h80);
    xl(5'h01, 8'h2A, 8'h00);
    xl(5'h01, 8'hD5, 8'hFE);
    xl(5'h04, 8'h80, 8'hAA);
    xl(5'h04, 8'hFF, 8'hD5);
    xl(5'h0B, 8'hFF, 8'hFF);
    for (k = 0; snk_u.got.size() < exp_q.size() && k < 500; k++) @(posedge clk);
    chk("count", exp_q.size(), snk_u.got.size());
    for (i = 0; i < exp_q.size() && i < snk_u.got.size(); i++)
      chk("out pair", exp_q[i], snk_u.got[i]);
    $display("test translate done");
    finish_test();
  end
endmodule
`default_nettype wire
